// file: rtl/fpm_top.sv
`timescale 1ns/1ps
`include "fpm_map.svh"
// Function
// - edits commit only from select press to select confirmed at save prompt
// - twelve seconds without switch activity abandons the edit session
// - committed settings kept in nonvolatile store, reloaded after reset
// - power-up shows all segments, then version, then frequency and gain
// - horizontal switch moves cursor one place left or right
// - vertical switch steps digit under cursor in frequency or gain menu
// - vertical switch toggles on/off items regardless of direction
// - edited frequency reaches hardware only after yes at save prompt
// - carrier mute asserted while a frequency change is applied
// - return marker plus select opens save prompt; yes stores, no restores
// - gain edits apply live; stored on yes, reverted on no or timeout
// - gain vertical step is 10 dB or 1 dB by cursor digit
// - gain limited to 0..50 dB, out-of-range steps rejected
// - select presses step menus 1..8 in order, then save menu
// - any PLL unlock raises summary alarm and alarm LED
// - mute LED follows mute selection, remote LED follows remote mode
// - serial link 9600 baud, 8 data bits, no parity, one stop bit
// - each executed serial command is answered with one '>' character
// - frequency limited to 0950..2150 MHz, four BCD digits
module fpm_top #(
  parameter int unsigned TIMEOUT_CYC = `FPM_TIMEOUT_CYC,
  parameter int unsigned STAGE_CYC   = `FPM_STAGE_CYC,
  parameter int unsigned DEB_CYC     = `FPM_DEB_CYC,
  parameter int unsigned MUTE_CYC    = `FPM_MUTE_CYC,
  parameter logic [7:0]  FW_VERSION  = 8'h11  // arbitrary value
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              sw_sel_i,
  input  wire logic              sw_left_i,
  input  wire logic              sw_right_i,
  input  wire logic              sw_up_i,
  input  wire logic              sw_down_i,
  input  wire logic [1:0]        pll_unlock_i,
  input  wire logic              uart_rx_i,
  output logic                   uart_tx_o,
  input  wire logic [30:0]       nv_data_i,
  output logic [30:0]            nv_data_o,
  output logic                   nv_we_o,
  output logic [15:0]            freq_o,
  output logic [5:0]             gain_o,
  output logic [3:0]             flags_o,
  output logic [4:0]             bus_addr_o,
  output logic                   carrier_mute_o,
  output logic                   alarm_led_o,
  output logic                   mute_led_o,
  output logic                   remote_led_o,
  output fpm_pkg::fpm_state_e    lcd_stage_o,
  output fpm_pkg::fpm_menu_t     lcd_menu_o,
  output logic [2:0]             lcd_cursor_o,
  output logic [15:0]            lcd_freq_o,
  output logic [5:0]             lcd_gain_o,
  output logic                   lcd_yes_o,
  output logic [7:0]             lcd_version_o
);
  import fpm_pkg::*;

  // ----------------------------------------------------------------------
  // switch inputs
  // ----------------------------------------------------------------------
  logic [4:0] raw_sw;
  logic [4:0] press;
  assign raw_sw = {sw_down_i, sw_up_i, sw_right_i, sw_left_i, sw_sel_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_deb
      fpm_debounce #(.CYC(DEB_CYC)) u_deb (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (raw_sw[gi]),
        .press_o (press[gi])
      );
    end
  endgenerate

  wire p_sel   = press[0];
  wire p_left  = press[1];
  wire p_right = press[2];
  wire p_vert  = press[3] | press[4];
  wire up      = press[3];
  wire any_p   = |press;

  logic [1:0] pll_s1_q;
  logic [1:0] pll_s2_q;
  always_ff @(posedge clk_i)
  begin
    pll_s1_q <= rst_i ? 2'h0 : pll_unlock_i;
    pll_s2_q <= rst_i ? 2'h0 : pll_s1_q;
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  fpm_state_e  st_q;
  fpm_menu_t   menu_q;
  logic [2:0]  cur_q;
  logic        yes_q;
  logic [31:0] tmr_q;
  logic        loaded_q;
  logic [15:0] freq_q;
  logic [5:0]  gain_q;
  logic [3:0]  flags_q;
  logic [4:0]  addr_q;
  logic [15:0] ed_freq_q;
  logic [5:0]  ed_gain_q;
  logic [3:0]  ed_flags_q;
  logic [4:0]  ed_addr_q;
  logic [31:0] mute_tmr_q;
  logic        ctrl_mute_q;
  logic        rx_vld;
  logic [7:0]  rx_byte;
  logic        rc_freq;
  logic        rc_gain;
  logic        rc_rdis;
  logic        rc_ren;
  logic [15:0] rc_dig;
  logic [6:0]  rc_gval;

  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] pos,
                                           input logic inc);
    logic [3:0]  d;
    logic [15:0] r;
    r = v;
    d = v[4*(3-pos) +: 4];
    if (inc)
      d = (d == 4'h9) ? 4'h0 : d + 4'h1;
    else
      d = (d == 4'h0) ? 4'h9 : d - 4'h1;
    r[4*(3-pos) +: 4] = d;
    return r;
  endfunction

  function automatic logic freq_ok(input logic [15:0] v);
    return (v >= `FPM_FREQ_MIN) && (v <= `FPM_FREQ_MAX) && (v[11:8] <= 4'h9)
           && (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction

  wire [15:0] f_step = bcd_step(ed_freq_q, cur_q[1:0], up);
  wire        f_ok   = freq_ok(f_step);
  // 10 dB on tens digit, 1 dB on units
  wire [6:0]  g_inc  = (cur_q == 3'h0) ? 7'h0A : 7'h01;
  wire [6:0]  g_step = up ? {1'b0, ed_gain_q} + g_inc : {1'b0, ed_gain_q} - g_inc;
  wire        g_ok   = (g_step <= `FPM_GAIN_MAX);
  wire        gain_m = (menu_q == 4'h2);
  wire        tog_m  = (menu_q >= 4'h3) && (menu_q <= 4'h6);
  wire [1:0]  tog_ix = 2'(menu_q - 4'h3);
  wire        is_ret = (cur_q == `FPM_CUR_RET);
  wire        editing = (st_q == ST_EDIT) || (st_q == ST_SAVE);
  wire        idle_out = editing && (tmr_q == TIMEOUT_CYC - 1);
  wire        commit = (st_q == ST_SAVE) && p_sel && yes_q && !idle_out;
  wire        rc_f_ok = rc_freq && freq_ok(rc_dig);
  wire        rc_g_ok = rc_gain && (rc_gval <= `FPM_GAIN_MAX);
  wire [2:0]  cur_r  = (gain_m && cur_q == 3'h1) ? `FPM_CUR_RET : cur_q + 3'h1;
  wire [2:0]  cur_l  = (gain_m && is_ret) ? 3'h1 : cur_q - 3'h1;

  // ----------------------------------------------------------------------
  // menu sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q   <= ST_LAMP;
      menu_q <= 4'h0;
      cur_q  <= 3'h0;
      yes_q  <= 1'b0;
      tmr_q  <= 32'h0;
    end
    else
    begin
      tmr_q <= tmr_q + 32'h1;
      unique case (st_q)
        ST_LAMP, ST_VER, ST_SHOW:
          if (tmr_q == STAGE_CYC - 1)
          begin
            tmr_q <= 32'h0;
            st_q  <= (st_q == ST_LAMP) ? ST_VER : (st_q == ST_VER) ? ST_SHOW : ST_NORM;
          end
        ST_NORM:
        begin
          tmr_q <= 32'h0;
          if (p_sel)
          begin
            st_q   <= ST_EDIT;
            menu_q <= 4'h1;
            cur_q  <= 3'h0;
          end
        end
        ST_EDIT, ST_SAVE:
        begin
          if (any_p)
            tmr_q <= 32'h0;
          if (idle_out)
          begin
            st_q   <= ST_NORM;
            menu_q <= 4'h0;
          end
          else if (st_q == ST_SAVE)
          begin
            if (p_vert)
              yes_q <= ~yes_q;
            if (p_sel)
            begin
              st_q   <= ST_NORM;
              menu_q <= 4'h0;
            end
          end
          else if (p_sel)
          begin
            cur_q <= 3'h0;
            if (is_ret || menu_q == `FPM_MENU_LAST)
            begin
              st_q  <= ST_SAVE;
              yes_q <= 1'b0;
            end
            else
              menu_q <= menu_q + 4'h1;
          end
          else if (p_right && !is_ret)
            cur_q <= cur_r;
          else if (p_left && cur_q != 3'h0)
            cur_q <= cur_l;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // edit copy
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ed_freq_q  <= `FPM_RST_FREQ;
      ed_gain_q  <= `FPM_RST_GAIN;
      ed_flags_q <= 4'h0;
      ed_addr_q  <= 5'h00;
    end
    else if (!editing)
    begin
      ed_freq_q  <= freq_q;
      ed_gain_q  <= gain_q;
      ed_flags_q <= flags_q;
      ed_addr_q  <= addr_q;
    end
    else if (st_q == ST_EDIT && p_vert && !is_ret)
    begin
      if (menu_q == 4'h1 && f_ok)
        ed_freq_q <= f_step;
      if (gain_m && g_ok && cur_q <= 3'h1)
        ed_gain_q <= g_step[5:0];
      if (tog_m)
        ed_flags_q[tog_ix] <= ~ed_flags_q[tog_ix];
      if (menu_q == 4'h7)
        ed_addr_q <= up ? ed_addr_q + 5'h01 : ed_addr_q - 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // committed settings
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loaded_q   <= 1'b0;
      freq_q     <= `FPM_RST_FREQ;
      gain_q     <= `FPM_RST_GAIN;
      flags_q    <= 4'h0;
      addr_q     <= 5'h00;
      nv_we_o    <= 1'b0;
      mute_tmr_q <= 32'h0;
    end
    else
    begin
      loaded_q <= 1'b1;
      nv_we_o  <= 1'b0;
      if (mute_tmr_q != 32'h0)
        mute_tmr_q <= mute_tmr_q - 32'h1;
      if (!loaded_q)
      begin
        {freq_q, gain_q, flags_q, addr_q} <= nv_data_i;
      end
      else if (commit)
      begin
        freq_q  <= ed_freq_q;
        gain_q  <= ed_gain_q;
        flags_q <= ed_flags_q;
        addr_q  <= ed_addr_q;
        nv_we_o <= 1'b1;
        if (ed_freq_q != freq_q)
          mute_tmr_q <= MUTE_CYC;
      end
      else if (rc_f_ok || rc_g_ok || rc_ren || rc_rdis)
      begin
        if (rc_f_ok)
        begin
          freq_q     <= rc_dig;
          mute_tmr_q <= MUTE_CYC;
        end
        if (rc_g_ok)
          gain_q <= rc_gval[5:0];
        if (rc_ren || rc_rdis)
          flags_q[0] <= rc_ren;
        nv_we_o <= 1'b1;
      end
    end
  end

  assign nv_data_o = {freq_q, gain_q, flags_q, addr_q};

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      freq_o         <= `FPM_RST_FREQ;
      gain_o         <= `FPM_RST_GAIN;
      carrier_mute_o <= 1'b1;
      alarm_led_o    <= 1'b0;
      mute_led_o     <= 1'b0;
      remote_led_o   <= 1'b0;
      lcd_gain_o     <= `FPM_RST_GAIN;
      lcd_freq_o     <= `FPM_RST_FREQ;
    end
    else
    begin
      freq_o         <= freq_q;
      // gain follows edits live, reverts when session ends without a yes at the save prompt
      gain_o         <= editing ? ed_gain_q : gain_q;
      carrier_mute_o <= (mute_tmr_q != 32'h0) || ctrl_mute_q;
      alarm_led_o    <= |pll_s2_q;
      mute_led_o     <= ctrl_mute_q;
      remote_led_o   <= flags_q[0];
      lcd_gain_o     <= editing ? ed_gain_q : gain_q;
      lcd_freq_o     <= editing ? ed_freq_q : freq_q;
    end
  end

  assign flags_o       = flags_q;
  assign bus_addr_o    = addr_q;
  assign lcd_stage_o   = st_q;
  assign lcd_menu_o    = menu_q;
  assign lcd_cursor_o  = cur_q;
  assign lcd_yes_o     = yes_q;
  assign lcd_version_o = FW_VERSION;

  // ----------------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------------
  fpm_uart u_uart (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .rx_i    (uart_rx_i),
    .tx_o    (uart_tx_o),
    .vld_o   (rx_vld),
    .byte_o  (rx_byte),
    .freq_o  (rc_freq),
    .gain_o  (rc_gain),
    .rdis_o  (rc_rdis),
    .ren_o   (rc_ren),
    .dig_o   (rc_dig)
  );
  assign rc_gval = 7'({3'h0, rc_dig[11:8]} * 7'h0A) + {3'h0, rc_dig[7:4]};

  // ----------------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------------
  wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        a_stat  = (wb_adr_i == `FPM_REG_STATUS);
  wire        a_set   = (wb_adr_i == `FPM_REG_SETTINGS);
  wire        a_ctrl  = (wb_adr_i == `FPM_REG_CTRL);
  wire [31:0] r_stat  = {17'h00000, alarm_led_o, flags_q[0], ctrl_mute_q, yes_q, 3'(st_q),
                         cur_q, menu_q, 1'b0};
  wire [31:0] r_set   = {10'h0, gain_q, freq_q};
  wire [31:0] rd_mux  = a_stat ? r_stat : a_set ? r_set :
                        a_ctrl ? {31'h0, ctrl_mute_q} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0;
      ctrl_mute_q <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
      if (wb_req && wb_we_i && a_ctrl && wb_sel_i[0])
        ctrl_mute_q <= wb_dat_i[`FPM_CTRL_MUTE];
    end
  end

  logic unused_rx;
  assign unused_rx = rx_vld ^ (^rx_byte);

endmodule // fpm_top

// ----------------------------------------------------------------------
// serial receiver, command parser and acknowledge sender
// ----------------------------------------------------------------------
module fpm_uart (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rx_i,
  output logic             tx_o,
  output logic             vld_o,
  output logic [7:0]       byte_o,
  output logic             freq_o,
  output logic             gain_o,
  output logic             rdis_o,
  output logic             ren_o,
  output logic [15:0]      dig_o
);
  localparam logic [11:0] BIT = 12'(`FPM_BIT_CYC);

  logic       s1_q;
  logic       s2_q;
  logic       busy_q;
  logic [11:0] tm_q;
  logic [3:0] ix_q;
  logic       inf_q;
  logic [2:0] n_q;
  logic [7:0] num_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_n_q;
  logic [11:0] tx_tm_q;

  wire close = vld_o && inf_q && byte_o == `FPM_CH_CLOSE;
  wire hash  = vld_o && byte_o == `FPM_CH_HASH;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      busy_q <= 1'b0;
      tm_q <= 12'h0;
      ix_q <= 4'h0;
      vld_o <= 1'b0;
      byte_o <= 8'h00;
    end
    else
    begin
      s1_q  <= rx_i;
      s2_q  <= s1_q;
      vld_o <= 1'b0;
      if (!busy_q && !s2_q)
      begin
        busy_q <= 1'b1;
        tm_q   <= BIT >> 1;
        ix_q   <= 4'h0;
      end
      else if (busy_q && tm_q != 12'h0)
        tm_q <= tm_q - 12'h1;
      else if (busy_q)
      begin
        tm_q <= BIT - 12'h1;
        ix_q <= ix_q + 4'h1;
        if (ix_q == 4'h9)
        begin
          busy_q <= 1'b0;
          vld_o  <= s2_q;
        end
        else if (ix_q == 4'h0 && s2_q)
          busy_q <= 1'b0;
        else if (ix_q != 4'h0)
          byte_o <= {s2_q, byte_o[7:1]};
      end
    end
  end

  // command frames and the acknowledge character
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      inf_q <= 1'b0;
      n_q <= 3'h0;
      num_q <= 8'h00;
      dig_o <= 16'h0;
      tx_sh_q <= 10'h3FF;
      tx_n_q <= 4'h0;
      tx_tm_q <= 12'h0;
    end
    else
    begin
      if (vld_o && byte_o == `FPM_CH_OPEN)
      begin
        inf_q <= 1'b1;
        n_q   <= 3'h0;
        dig_o <= 16'h0;
      end
      else if (close)
        inf_q <= 1'b0;
      else if (vld_o && inf_q)
      begin
        n_q <= (n_q == 3'h7) ? n_q : n_q + 3'h1;
        if (n_q == 3'h1)
          num_q <= byte_o;
        else if (n_q >= 3'h2)
          dig_o <= {dig_o[11:0], byte_o[3:0]};
      end
      if (close || hash)
      begin
        tx_sh_q <= {1'b1, `FPM_CH_ACK, 1'b0};
        tx_n_q  <= 4'hA;
        tx_tm_q <= BIT - 12'h1;
      end
      else if (tx_n_q != 4'h0)
      begin
        if (tx_tm_q != 12'h0)
          tx_tm_q <= tx_tm_q - 12'h1;
        else
        begin
          tx_tm_q <= BIT - 12'h1;
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          tx_n_q  <= tx_n_q - 4'h1;
        end
      end
    end
  end

  assign tx_o   = (tx_n_q == 4'h0) ? 1'b1 : tx_sh_q[0];
  assign freq_o = close && num_q == `FPM_CH_FREQ;
  assign gain_o = close && num_q == `FPM_CH_GAIN;
  assign rdis_o = close && num_q == `FPM_CH_RDIS;
  assign ren_o  = hash;

endmodule // fpm_uart

// file: rtl/fpm_map.svh
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define FPM_CLK_HZ        20000000
`define FPM_BAUD          9600
`define FPM_BIT_CYC       (`FPM_CLK_HZ / `FPM_BAUD)
`define FPM_TIMEOUT_S     12
`define FPM_TIMEOUT_CYC   (`FPM_TIMEOUT_S * `FPM_CLK_HZ)
`define FPM_STAGE_MS      1000
`define FPM_STAGE_CYC     (`FPM_STAGE_MS * (`FPM_CLK_HZ / 1000))
`define FPM_DEB_MS        10
`define FPM_DEB_CYC       (`FPM_DEB_MS * (`FPM_CLK_HZ / 1000))
`define FPM_MUTE_MS       50
`define FPM_MUTE_CYC      (`FPM_MUTE_MS * (`FPM_CLK_HZ / 1000))

// ----------------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------------
`define FPM_REG_STATUS    8'h00
`define FPM_REG_SETTINGS  8'h04
`define FPM_REG_CTRL      8'h08
`define FPM_CTRL_MUTE     0

// ----------------------------------------------------------------------
// value ranges and reset values
// ----------------------------------------------------------------------
`define FPM_FREQ_MIN      16'h0950
`define FPM_FREQ_MAX      16'h2150
`define FPM_GAIN_MAX      7'h32
`define FPM_RST_FREQ      16'h0950
`define FPM_RST_GAIN      6'h00
`define FPM_CUR_RET       3'h4
`define FPM_MENU_LAST     4'h8
`define FPM_ADDR_MAX      5'h1F

// ----------------------------------------------------------------------
// serial characters
// ----------------------------------------------------------------------
`define FPM_CH_ACK        8'h3E
`define FPM_CH_OPEN       8'h7B
`define FPM_CH_CLOSE      8'h7D
`define FPM_CH_HASH       8'h23
`define FPM_CH_FREQ       8'h32
`define FPM_CH_GAIN       8'h34
`define FPM_CH_RDIS       8'h52

`endif

// file: rtl/fpm_pkg.sv
package fpm_pkg;

  typedef enum logic [2:0] {
    ST_LAMP,
    ST_VER,
    ST_SHOW,
    ST_NORM,
    ST_EDIT,
    ST_SAVE
  } fpm_state_e;

  typedef logic [3:0] fpm_menu_t;

endpackage

// file: rtl/fpm_debounce.sv
`timescale 1ns/1ps
module fpm_debounce #(
  parameter int unsigned CYC = 200000
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      press_o
);

  logic        s1_q;
  logic        s2_q;
  logic        stable_q;
  logic [31:0] cnt_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q     <= 1'b0;
      s2_q     <= 1'b0;
      stable_q <= 1'b0;
      cnt_q    <= 32'h0;
      press_o  <= 1'b0;
    end
    else
    begin
      s1_q    <= raw_i;
      s2_q    <= s1_q;
      press_o <= 1'b0;
      if (s2_q == stable_q)
        cnt_q <= 32'h0;
      else if (cnt_q == CYC - 1)
      begin
        cnt_q    <= 32'h0;
        stable_q <= s2_q;
        press_o  <= s2_q;
      end
      else
        cnt_q <= cnt_q + 32'h1;
    end
  end

endmodule // fpm_debounce

// file: test/fpm_operator.sv
`timescale 1ns/1ps
// ------
// front-panel operator: one bouncy activation per request
// ------
module fpm_operator #(
  parameter int HOLD = 12
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [2:0] key_i,
  output logic      [4:0] sw_o,
  output logic            busy_o
);
  logic [5:0] cnt_q;
  logic       on;
  always_ff @(posedge clk_i)
    if (rst_i || cnt_q == 6'(2 * HOLD))
      cnt_q <= 6'h00;
    else if (cnt_q != 6'h00 || go_i)
      cnt_q <= cnt_q + 6'h01;
  // contact bounce: blip, gap, then held
  assign on = cnt_q == 6'h01 || (cnt_q > 6'h02 && cnt_q < 6'(HOLD));
  assign sw_o = on ? 5'h01 << key_i : 5'h00;
  assign busy_o = cnt_q != 6'h00;
endmodule // fpm_operator

// file: test/fpm_top_asserts.sv
`timescale 1ns/1ps
module fpm_checker (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic [1:0]          pll_unlock_i,
  input wire logic                alarm_led_o,
  input wire logic [3:0]          flags_o,
  input wire logic                remote_led_o,
  input wire logic                nv_we_o,
  input wire logic [30:0]         nv_data_o,
  input wire logic [15:0]         freq_o,
  input wire logic                carrier_mute_o,
  input wire logic [5:0]          gain_o,
  input wire logic                uart_tx_o,
  input wire fpm_pkg::fpm_state_e lcd_stage_o
);
  import fpm_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  alarm_on_a: assert property ((|pll_unlock_i) [*5] |-> alarm_led_o)
    else $error("alarm led missing");
  alarm_off_a: assert property (!(|pll_unlock_i) [*5] |-> !alarm_led_o)
    else $error("alarm led stuck");
  remote_led_a: assert property ($stable(flags_o[0]) |-> remote_led_o == flags_o[0])
    else $error("remote led wrong");
  mute_commit_a: assert property (nv_we_o && nv_data_o[30:15] != freq_o |-> ##[0:2] carrier_mute_o)
    else $error("no mute on frequency change");
  gain_range_a: assert property (gain_o <= 6'h32)
    else $error("gain out of range");
  stage_order_a: assert property (lcd_stage_o == ST_VER |-> $past(lcd_stage_o) inside {ST_LAMP, ST_VER})
    else $error("power-up order wrong");
  nv_pulse_a: assert property (nv_we_o |=> !nv_we_o)
    else $error("store strobe too long");
  tx_start_a: assert property ($fell(uart_tx_o) |=> !uart_tx_o [*8])
    else $error("start bit too short");
  cover property (nv_we_o);
  cover property ($rose(alarm_led_o));
  cover property (lcd_stage_o == ST_SAVE);
endmodule // fpm_checker

bind fpm_top fpm_checker chk_u (.*);

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fpm_pkg::*;
  localparam int SEL = 0, LT = 1, RT = 2, UP = 3, DN = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, uart_rx_i = 1'b1, go = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, b;
  logic [3:0] wb_sel_i = 4'hF, flags_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic [1:0] pll_unlock_i = 2'h0;
  logic [30:0] nv_data_i = {16'h1234, 6'h05, 9'h000}, nv_data_o;
  logic [2:0] key = 3'h0, lcd_cursor_o;
  logic [15:0] freq_o, lcd_freq_o;
  logic [5:0] gain_o, lcd_gain_o;
  logic [4:0] bus_addr_o;
  logic [7:0] lcd_version_o;
  logic sw_sel_i, sw_left_i, sw_right_i, sw_up_i, sw_down_i, busy, wb_ack_o, uart_tx_o;
  logic nv_we_o, carrier_mute_o, alarm_led_o, mute_led_o, remote_led_o, lcd_yes_o;
  fpm_state_e lcd_stage_o;
  fpm_menu_t lcd_menu_o;
  int fail_count = 0, samples_checked = 0;
  always #25 clk_i = ~clk_i;
  fpm_top #(.TIMEOUT_CYC(2000), .STAGE_CYC(50), .DEB_CYC(4), .MUTE_CYC(20)) uut (.*);
  fpm_operator op_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .key_i(key),
    .sw_o({sw_down_i, sw_up_i, sw_right_i, sw_left_i, sw_sel_i}), .busy_o(busy));
  // ------
  // tasks
  // ------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timed_out;
    fail_count++;
    tally_and_finish();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic press(input int k);
    int n;
    n = 0;
    @(posedge clk_i);
    key <= 3'(k);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    while (busy)
    begin
      @(posedge clk_i);
      if (++n > 60) timed_out();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
      if (++n > 20) timed_out();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic ser_xfer(input logic [7:0] c);
    int n;
    n = 0;
    for (int i = 0; i < 9; i++)
    begin
      uart_rx_i <= i == 0 ? 1'b0 : c[i-1];
      repeat (2083) @(posedge clk_i);
    end
    uart_rx_i <= 1'b1;
    while (uart_tx_o !== 1'b0)
    begin
      @(posedge clk_i);
      if (++n > 5000) timed_out();
    end
    repeat (1041) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (2083) @(posedge clk_i);
      b[i] = uart_tx_o;
    end
  endtask
  // ------
  // main sequence
  // ------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 300 && lcd_stage_o !== ST_NORM; i++) @(posedge clk_i);
    chk("stage", 32'(ST_NORM), 32'(lcd_stage_o));
    chk("freq", 32'h1234, 32'(freq_o));
    for (int i = 1; i < 9; i++)
    begin
      press(SEL);
      chk("menu", 32'(i), 32'(lcd_menu_o));
      if (i == 4 || i == 7) press(DN);
    end
    press(SEL);
    chk("prompt", 32'(ST_SAVE), 32'(lcd_stage_o));
    press(UP);
    press(SEL);
    chk("flags", 32'h2, 32'(flags_o));
    chk("addr", 32'h1F, 32'(bus_addr_o));
    press(SEL);
    press(SEL);
    press(UP);
    chk("gain10", 32'h0F, 32'(gain_o));
    chk("lcdgain", 32'h0F, 32'(lcd_gain_o));
    press(RT);
    press(UP);
    chk("gain1", 32'h10, 32'(gain_o));
    press(LT);
    repeat (4) press(UP);
    chk("gainmax", 32'h2E, 32'(gain_o));
    press(RT);
    press(RT);
    chk("cursor", 32'h4, 32'(lcd_cursor_o));
    press(SEL);
    chk("prompt", 32'(ST_SAVE), 32'(lcd_stage_o));
    press(SEL);
    chk("gainback", 32'h05, 32'(gain_o));
    press(SEL);
    press(UP);
    chk("freqbad", 32'h1234, 32'(lcd_freq_o));
    press(RT);
    press(UP);
    chk("freqedit", 32'h1334, 32'(lcd_freq_o));
    chk("freqheld", 32'h1234, 32'(freq_o));
    repeat (3) press(RT);
    press(SEL);
    press(UP);
    chk("yes", 32'h1, 32'(lcd_yes_o));
    press(DN);
    chk("no", 32'h0, 32'(lcd_yes_o));
    press(UP);
    press(SEL);
    chk("freqnew", 32'h1334, 32'(freq_o));
    chk("stored", 32'h1334, 32'(nv_data_o[30:15]));
    chk("muted", 32'h1, 32'(carrier_mute_o));
    press(SEL);
    press(RT);
    press(DN);
    chk("freqdn", 32'h1234, 32'(lcd_freq_o));
    repeat (1900) @(posedge clk_i);
    chk("open", 32'(ST_EDIT), 32'(lcd_stage_o));
    repeat (200) @(posedge clk_i);
    chk("closed", 32'(ST_NORM), 32'(lcd_stage_o));
    chk("unmuted", 32'h0, 32'(carrier_mute_o));
    chk("freqkept", 32'h1334, 32'(lcd_freq_o));
    pll_unlock_i <= 2'h2;
    repeat (5) @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0);
    chk("alarmbit", 32'h1, 32'(r[14]));
    pll_unlock_i <= 2'h0;
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("settings", 32'h00051334, r);
    chk("muteled", 32'h1, 32'(mute_led_o));
    wb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, r);
    chk("alarmoff", 32'h0, 32'(alarm_led_o));
    ser_xfer(8'h23);
    chk("ack", 32'h3E, 32'(b));
    chk("remote", 32'h1, 32'(remote_led_o));
    chk("flagsrem", 32'h3, 32'(flags_o));
    tally_and_finish();
  end
endmodule // tb_top
